//--- odcd_assertions.sv
// Concurrent checks on the command decoder top ports
`timescale 1ns/1ns
`default_nettype none
module odcd_assertions #(
  parameter int WAKE_COUNT = 4
) (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic [63:0] CHANNEL_OUT,
  input wire logic [63:0] CHANNEL_REG,
  input wire logic [7:0]  POWER_DOWN,
  input wire logic [7:0]  SETTLING,
  input wire logic        WRITE_THROUGH_MODE,
  input wire logic        BIAS_ENABLE,
  input wire logic        FRAME_DONE,
  input wire logic        FRAME_ABORT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  int unsigned settle_cnt_reg;
  // Counter, since a repetition cannot take the parameter
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_cnt_reg <= 0;
    end else begin
      settle_cnt_reg <= SETTLING[0] ? settle_cnt_reg + 1 : 0;
    end
  end
  sequence s_wake;
    $fell(POWER_DOWN[0]);
  endsequence
  sequence s_abort;
    FRAME_ABORT;
  endsequence
  a_reset_clear: assert property ($rose(RESET_N) |-> CHANNEL_OUT == 0 && CHANNEL_REG == 0 && !WRITE_THROUGH_MODE)
    else $error("state not clear after reset");
  a_done_pulse: assert property (FRAME_DONE |=> !FRAME_DONE && !FRAME_ABORT)
    else $error("done pulse too long");
  a_abort_quiet: assert property (s_abort |=> ($stable(CHANNEL_REG) && $stable(CHANNEL_OUT)) [*2])
    else $error("aborted frame changed channels");
  a_bias_rule: assert property (BIAS_ENABLE == !(&POWER_DOWN))
    else $error("bias enable wrong");
  a_pd_keeps_reg: assert property ((POWER_DOWN & ~$past(POWER_DOWN)) != 8'h00 |-> $stable(CHANNEL_REG))
    else $error("power-down altered data");
  a_mode_hold: assert property ($changed(WRITE_THROUGH_MODE) |-> FRAME_DONE)
    else $error("mode changed without frame");
  a_out_needs_frame: assert property ($changed(CHANNEL_OUT) |-> $past(FRAME_DONE))
    else $error("output changed without frame");
  a_wake_settles: assert property (s_wake |-> ##[0:1] SETTLING[0])
    else $error("woken channel not settling");
  a_settle_bound: assert property (settle_cnt_reg <= WAKE_COUNT + 1)
    else $error("settling too long");
endmodule
bind odcd_top odcd_assertions #(.WAKE_COUNT(WAKE_COUNT)) u_odcd_assertions (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CHANNEL_OUT(CHANNEL_OUT), .CHANNEL_REG(CHANNEL_REG),
  .POWER_DOWN(POWER_DOWN), .SETTLING(SETTLING), .WRITE_THROUGH_MODE(WRITE_THROUGH_MODE),
  .BIAS_ENABLE(BIAS_ENABLE), .FRAME_DONE(FRAME_DONE), .FRAME_ABORT(FRAME_ABORT));
`default_nettype wire

//--- odcd_channel.sv
// One output channel: data register, output latch, power-down and wake timer
`timescale 1ns/1ns
`default_nettype none
module odcd_channel #(
  parameter int WAKE_COUNT = odcd_pkg::WAKE_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    load_reg,
  input  wire logic                    load_out,
  input  wire logic [7:0]              new_data,
  input  wire logic                    power_down,
  input  wire logic [1:0]              term_mode,
  output logic      [7:0]              data_reg,
  output logic      [7:0]              out_reg,
  output logic                         pd_reg,
  output logic      [1:0]              term_reg,
  output logic                         settling_reg
);
  localparam int WAKE_W = odcd_pkg::WAKE_W;
  logic [odcd_pkg::WAKE_W-1:0] wake_cnt_reg;
  wire  [7:0] reg_value = load_reg ? new_data : data_reg;
  wire        wake      = load_out && pd_reg;
  wire        wake_done = (wake_cnt_reg == {odcd_pkg::WAKE_W{1'b0}});

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg     <= odcd_pkg::DATA_RESET;
      out_reg      <= odcd_pkg::DATA_RESET;
      pd_reg       <= 1'b0;
      term_reg     <= odcd_pkg::TERM_NONE;
      settling_reg <= 1'b0;
      wake_cnt_reg <= '0;
    end else begin
      data_reg <= reg_value;
      if (power_down) begin
        pd_reg       <= 1'b1;
        term_reg     <= term_mode;
        settling_reg <= 1'b0;
      end else if (load_out) begin
        out_reg  <= reg_value;
        pd_reg   <= 1'b0;
        term_reg <= odcd_pkg::TERM_NONE;
      end
      if (wake && !power_down) begin
        settling_reg <= 1'b1;
        wake_cnt_reg <= WAKE_W'(WAKE_COUNT - 1);
      end else if (settling_reg && !power_down) begin
        if (wake_done)
          settling_reg <= 1'b0;
        else
          wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- odcd_host.sv
// Host model driving three-wire command frames
`timescale 1ns/1ns
`default_nettype none
module odcd_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      sync_n,
  output logic      din
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // MSB first, one bit per falling edge
  task automatic send(input logic [15:0] frame, input int edges);
    sync_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < edges; i++) begin
      din = frame[15 - i];
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge clk);
    sync_n = 1'b1;
    // Released line must not keep showing the last bit
    din = ~din;
    repeat (12) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- odcd_pkg.sv
// Constants for the octal converter command decoder
package odcd_pkg;
  localparam int CHANNELS = 8;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int ABORT_EDGES = 15;
  localparam logic [3:0] CMD_REG_ONLY = 4'h8;
  localparam logic [3:0] CMD_WRITE_THRU = 4'h9;
  localparam logic [3:0] CMD_UPDATE_SEL = 4'hA;
  localparam logic [3:0] CMD_CHA_WRITE = 4'hB;
  localparam logic [3:0] CMD_BROADCAST = 4'hC;
  localparam logic [3:0] CMD_PD_HIZ = 4'hD;
  localparam logic [3:0] CMD_PD_100K = 4'hE;
  localparam logic [3:0] CMD_PD_2K5 = 4'hF;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int CHSEL_MSB = 14;
  localparam int CHSEL_LSB = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_LSB = 4;
  localparam int MASK_MSB = 7;
  localparam logic [1:0] TERM_HIZ = 2'h1;
  localparam logic [1:0] TERM_100K = 2'h2;
  localparam logic [1:0] TERM_2K5 = 2'h3;
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int CLK_HZ = 10_000_000;
  localparam int WAKE_NS = 20_000;
  localparam int WAKE_CYCLES = (WAKE_NS / (1_000_000_000 / CLK_HZ)) < 1 ? 1 :
                               (WAKE_NS / (1_000_000_000 / CLK_HZ));
  localparam int WAKE_W = 12;
  typedef enum logic [1:0] {
    ODCD_IDLE  = 2'b00,
    ODCD_SHIFT = 2'b01,
    ODCD_FULL  = 2'b10
  } odcd_state_type;
endpackage

//--- odcd_top.sv
// Serial command decoder for an eight-channel 8-bit converter
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - After reset the block is in register-only update mode
// - Command 1001 selects write-through mode, low twelve bits ignored
// - Command 1000 selects register-only mode, low twelve bits ignored
// - Bit 15 low means channel write; bits 14..12 pick channel A..H
// - Write-through updates register and output; register-only updates register
// - Special commands behave the same in either mode
// - Command 1010 loads outputs of channels whose low-byte bit is set
// - Command 1011 writes channel A fully and refreshes all other outputs
// - Channel-A write leaves the update mode unchanged
// - Command 1100 writes data to all registers and outputs
// - Reset clears registers and outputs to zero
// - Commands 1101, 1110, 1111 power down with hi-Z, 100k, 2.5k termination
// - Each set low-byte bit powers down its channel, A is bit 0
// - Bias enable drops only when all eight channels are powered down
// - Power-down leaves data registers unchanged
// - A woken channel is flagged settling for the wake-up interval
// - Channel data sits in bits 11..4; bits 3..0 ignored
// - Bits shift on falling serial clock while sync low; execute on sync rise
// - Sync rising before the fifteenth falling edge discards the frame
module odcd_top #(
  parameter int WAKE_COUNT = odcd_pkg::WAKE_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        SCLK_IN,
  input  wire logic        SYNC_N_IN,
  input  wire logic        DATA_IN,
  output logic      [63:0] CHANNEL_OUT,
  output logic      [63:0] CHANNEL_REG,
  output logic      [7:0]  POWER_DOWN,
  output logic      [15:0] TERMINATION,
  output logic      [7:0]  SETTLING,
  output logic             WRITE_THROUGH_MODE,
  output logic             BIAS_ENABLE,
  output logic             FRAME_DONE,
  output logic             FRAME_ABORT
);
  logic [1:0]  sclk_sync_reg;
  logic [1:0]  sync_sync_reg;
  logic [1:0]  din_sync_reg;
  logic        sclk_prev_reg;
  logic        sync_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0]  edge_cnt_reg;
  logic        write_through_mode_reg;
  logic        bias_reg;
  logic        done_reg;
  logic        abort_reg;
  odcd_pkg::odcd_state_type state_reg;
  odcd_pkg::odcd_state_type state_next;

  wire sclk_s   = sclk_sync_reg[1];
  wire sync_s   = sync_sync_reg[1];
  wire din_s    = din_sync_reg[1];
  wire sclk_fall = sclk_prev_reg && !sclk_s;
  wire sync_rise = !sync_prev_reg && sync_s;
  wire sync_low  = !sync_s;
  // Only a frame in progress takes bits; a full frame ignores the rest
  wire frame_open = (state_reg == odcd_pkg::ODCD_SHIFT);
  wire shift_en   = sync_low && sclk_fall && frame_open;
  wire last_edge  = sclk_fall && (edge_cnt_reg == 5'(odcd_pkg::FRAME_BITS - 1));

  wire execute = sync_rise && (edge_cnt_reg >= 5'(odcd_pkg::ABORT_EDGES));
  wire abort   = sync_rise && (edge_cnt_reg < 5'(odcd_pkg::ABORT_EDGES));

  // A 15-edge frame still executes, with its bits one place low;
  // hosts are expected to send all sixteen
  wire [3:0] cmd      = shift_reg[odcd_pkg::CMD_MSB:odcd_pkg::CMD_LSB];
  wire [2:0] chan_sel = shift_reg[odcd_pkg::CHSEL_MSB:odcd_pkg::CHSEL_LSB];
  wire [7:0] data_val = shift_reg[odcd_pkg::DATA_MSB:odcd_pkg::DATA_LSB];
  // channel mask, bit 0 is channel A
  wire [7:0] mask     = shift_reg[odcd_pkg::MASK_MSB:0];

  wire       is_chan_write = execute && !shift_reg[odcd_pkg::CMD_MSB];
  wire       is_upd_sel    = execute && (cmd == odcd_pkg::CMD_UPDATE_SEL);
  wire       is_cha_write  = execute && (cmd == odcd_pkg::CMD_CHA_WRITE);
  wire       is_broadcast  = execute && (cmd == odcd_pkg::CMD_BROADCAST);
  wire       is_wt_cmd     = execute && (cmd == odcd_pkg::CMD_WRITE_THRU);
  wire       is_ro_cmd     = execute && (cmd == odcd_pkg::CMD_REG_ONLY);
  wire       pd_hiz_code   = (cmd == odcd_pkg::CMD_PD_HIZ);
  wire       pd_100k_code  = (cmd == odcd_pkg::CMD_PD_100K);
  wire       pd_2k5_code   = (cmd == odcd_pkg::CMD_PD_2K5);
  wire       is_pd         = execute && (pd_hiz_code || pd_100k_code || pd_2k5_code);
  wire [1:0] term_sel = (cmd == odcd_pkg::CMD_PD_HIZ)  ? odcd_pkg::TERM_HIZ :
                        (cmd == odcd_pkg::CMD_PD_100K) ? odcd_pkg::TERM_100K :
                                                         odcd_pkg::TERM_2K5;
  wire [7:0] chan_onehot = 8'(1) << chan_sel;

  // Per-channel controls for, and state gathered from, the channel instances
  logic [7:0] load_reg_vec;
  logic [7:0] load_out_vec;
  logic [7:0] pd_vec;
  logic [7:0] pd_state;
  logic [7:0] ch_data [0:7];
  logic [7:0] ch_out  [0:7];
  logic [1:0] ch_term [0:7];
  logic [7:0] ch_settle;

  always_comb begin
    load_reg_vec = 8'h00;
    load_out_vec = 8'h00;
    pd_vec       = 8'h00;
    if (is_chan_write) begin
      load_reg_vec = chan_onehot;
      if (write_through_mode_reg)
        load_out_vec = chan_onehot;
    end
    if (is_upd_sel)
      load_out_vec = mask;
    if (is_cha_write) begin
      load_reg_vec = 8'h01;
      load_out_vec = 8'hFF;
    end
    if (is_broadcast) begin
      load_reg_vec = 8'hFF;
      load_out_vec = 8'hFF;
    end
    if (is_pd)
      pd_vec = mask;
  end

  genvar g;
  generate
    for (g = 0; g < odcd_pkg::CHANNELS; g++) begin : gen_ch
      odcd_channel #(.WAKE_COUNT(WAKE_COUNT)) u_ch (
        .clk          (CORE_CLK),
        .reset_n      (RESET_N),
        .load_reg     (load_reg_vec[g]),
        .load_out     (load_out_vec[g]),
        .new_data     (data_val),
        .power_down   (pd_vec[g]),
        .term_mode    (term_sel),
        .data_reg     (ch_data[g]),
        .out_reg      (ch_out[g]),
        .pd_reg       (pd_state[g]),
        .term_reg     (ch_term[g]),
        .settling_reg (ch_settle[g])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      odcd_pkg::ODCD_IDLE:
        if (sync_low)
          state_next = odcd_pkg::ODCD_SHIFT;
      odcd_pkg::ODCD_SHIFT:
        if (!sync_low)
          state_next = odcd_pkg::ODCD_IDLE;
        else if (last_edge)
          state_next = odcd_pkg::ODCD_FULL;
      odcd_pkg::ODCD_FULL:
        if (!sync_low)
          state_next = odcd_pkg::ODCD_IDLE;
      default:
        state_next = odcd_pkg::ODCD_IDLE;
    endcase
  end

  // Inputs come from another clock domain
  // The serial clock idles high, so its history resets high: no false edge
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_sync_reg <= 2'b11;
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], SCLK_IN};
      sclk_prev_reg <= sclk_s;
    end
  end

  // Sync idles high; a low history would fake a frame start
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_sync_reg <= 2'b11;
      sync_prev_reg <= 1'b1;
    end else begin
      sync_sync_reg <= {sync_sync_reg[0], SYNC_N_IN};
      sync_prev_reg <= sync_s;
    end
  end

  // Data needs no edge history; it is only read on a clock fall
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      din_sync_reg <= 2'b00;
    end else begin
      din_sync_reg <= {din_sync_reg[0], DATA_IN};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= odcd_pkg::ODCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shift_reg    <= 16'h0000;
      edge_cnt_reg <= 5'h00;
    end else begin
      if (state_reg == odcd_pkg::ODCD_IDLE) begin
        edge_cnt_reg <= 5'h00;
      end else if (shift_en) begin
        shift_reg    <= {shift_reg[14:0], din_s};
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
    end
  end

  // Pulses last one cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_reg  <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      done_reg  <= execute;
      abort_reg <= abort;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      write_through_mode_reg <= 1'b0;
    end else begin
      if (is_wt_cmd)
        write_through_mode_reg <= 1'b1;
      else if (is_ro_cmd)
        write_through_mode_reg <= 1'b0;
    end
  end

  // bias off only when all down
  // Follows the channel power-down flags so it moves together with POWER_DOWN
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bias_reg <= 1'b1;
    end else begin
      bias_reg <= ~&pd_state;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHANNEL_OUT <= 64'h0000_0000_0000_0000;
      CHANNEL_REG <= 64'h0000_0000_0000_0000;
      TERMINATION <= 16'h0000;
    end else begin
      for (int i = 0; i < odcd_pkg::CHANNELS; i++) begin
        CHANNEL_OUT[i*8 +: 8] <= ch_out[i];
        CHANNEL_REG[i*8 +: 8] <= ch_data[i];
        TERMINATION[i*2 +: 2] <= ch_term[i];
      end
    end
  end

  // Status flags take the same stage as the channel values
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      POWER_DOWN <= 8'h00;
      SETTLING   <= 8'h00;
    end else begin
      POWER_DOWN <= pd_state;
      SETTLING   <= ch_settle;
    end
  end

  // Outputs come straight from their flip-flops
  assign WRITE_THROUGH_MODE = write_through_mode_reg;
  assign BIAS_ENABLE        = bias_reg;
  assign FRAME_DONE         = done_reg;
  assign FRAME_ABORT        = abort_reg;
endmodule
`default_nettype wire

//--- odcd_top_test.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
module odcd_top_test;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         sclk, sync_n, din;
  logic [63:0] ch_out, ch_reg;
  logic [7:0]  pd, settle;
  logic [15:0] term;
  logic        write_through_mode, bias, done, abort_p;
  int          abort_cnt = 0;
  int          done_cnt = 0;
  logic        settle_seen = 1'b0;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #50 core_clk = ~core_clk;
  odcd_host u_odcd_host (.clk(core_clk), .sclk(sclk), .sync_n(sync_n), .din(din));
  // Short wake count keeps the settling window visible
  odcd_top #(.WAKE_COUNT(4)) u_odcd_top (
    .CORE_CLK(core_clk), .RESET_N(rst_n), .SCLK_IN(sclk), .SYNC_N_IN(sync_n), .DATA_IN(din),
    .CHANNEL_OUT(ch_out), .CHANNEL_REG(ch_reg), .POWER_DOWN(pd), .TERMINATION(term),
    .SETTLING(settle), .WRITE_THROUGH_MODE(write_through_mode), .BIAS_ENABLE(bias), .FRAME_DONE(done),
    .FRAME_ABORT(abort_p));
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (abort_p === 1'b1) abort_cnt <= abort_cnt + 1;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (settle[0] === 1'b1) settle_seen <= 1'b1;
    if (cyc == 10000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tx(input logic [15:0] f, input int n);
    u_odcd_host.send(f, n);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    check(ch_out, 64'h0);
    check(ch_reg, 64'h0);
    check(write_through_mode, 1'b0);
    check(bias, 1'b1);
  endtask
  task automatic t_reg_only();
    tx(16'h0FF0, 16);
    tx(16'h7AB5, 16);
    check(ch_reg, 64'hAB00_0000_0000_00FF);
    check(ch_out, 64'h0);
    check(done_cnt, 2);
  endtask
  task automatic t_abort();
    tx(16'h1C00, 13);
    check(abort_cnt, 1);
    tx(16'h1C00, 14);
    check(abort_cnt, 2);
    check(done_cnt, 2);
    check(ch_reg, 64'hAB00_0000_0000_00FF);
  endtask
  task automatic t_special();
    tx(16'hA081, 16);
    check(ch_out, 64'hAB00_0000_0000_00FF);
    tx(16'h1C00, 16);
    tx(16'h2800, 16);
    tx(16'hB550, 16);
    check(ch_reg, 64'hAB00_0000_0080_C055);
    check(ch_out, 64'hAB00_0000_0080_C055);
    check(write_through_mode, 1'b0);
  endtask
  task automatic t_write_thru();
    tx(16'h9FFF, 16);
    check(write_through_mode, 1'b1);
    tx(16'h6800, 16);
    check(ch_out, 64'hAB80_0000_0080_C055);
    tx(16'hC3C0, 16);
    check(ch_out, {8{8'h3C}});
    tx(16'h8123, 16);
    check(write_through_mode, 1'b0);
  endtask
  task automatic t_power();
    tx(16'hD081, 16);
    check(pd, 8'h81);
    check(term, 16'h4001);
    check(ch_reg, {8{8'h3C}});
    tx(16'hE002, 16);
    check(term, 16'h4009);
    check(bias, 1'b1);
    tx(16'hF07C, 16);
    check(term, 16'h7FF9);
    check(bias, 1'b0);
    tx(16'h0550, 16);
    check(ch_out[7:0], 8'h3C);
    tx(16'hA001, 16);
    check(pd, 8'hFE);
    check(ch_out[7:0], 8'h55);
    check(bias, 1'b1);
    check(settle_seen, 1'b1);
    check(settle, 8'h00);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_reg_only();
    t_abort();
    t_special();
    t_write_thru();
    t_power();
    report_and_stop();
  end
endmodule
`default_nettype wire
